// [inc/t2crc_defines.vh]
`ifndef T2CRC_DEFINES_VH
`define T2CRC_DEFINES_VH

// special register addresses
`define T2CRC_ADDR_CTRL      8'hc8
`define T2CRC_ADDR_MODE      8'hc9
`define T2CRC_ADDR_RLD_LO    8'hca
`define T2CRC_ADDR_RLD_HI    8'hcb
`define T2CRC_ADDR_CNT_LO    8'hcc
`define T2CRC_ADDR_CNT_HI    8'hcd

// timer_two_control bit positions
`define T2CRC_CTRL_OVF       7
`define T2CRC_CTRL_EXT       6
`define T2CRC_CTRL_RCLK      5
`define T2CRC_CTRL_TRANSMIT_CLOCK_SELECT      4
`define T2CRC_CTRL_EXEN      3
`define T2CRC_CTRL_RUN       2
`define T2CRC_CTRL_FUNC      1
`define T2CRC_CTRL_CPRL      0

// timer_two_mode bit positions
`define T2CRC_MODE_OE        1
`define T2CRC_MODE_DIRECTION_ENABLE      0

// reset values
`define T2CRC_RST_CTRL       8'h00
`define T2CRC_RST_MODE       2'h0
`define T2CRC_RST_BYTE       8'h00

// timing in oscillator periods
`define T2CRC_OSC_PER_MC     12
`define T2CRC_OSC_PER_STATE  2
`define T2CRC_PHASE_S3P1     4
`define T2CRC_PHASE_S5P2     9
`define T2CRC_CNT_MAX        16'hffff
`define T2CRC_CNT_ZERO       16'h0000

`endif

// [logic/t2crc.v]
// Behaviour
// [RULE_01] overflow flag, control bit 7, set on 16-bit overflow, cleared only by software
// [RULE_02] overflow flag never set while receive or transmit clock select is 1
// [RULE_03] external flag, bit 6, set when trigger falling edge captures or reloads
// [RULE_04] external flag requests interrupt when enabled, except in up/down mode; the code masks it whenever direction enable is 1
// [RULE_05] receive clock select, bit 5, gives receiver this timer's overflows, else timer 1
// [RULE_06] transmit clock select, bit 4, gives transmitter this timer's overflows, else timer 1
// [RULE_07] external enable, bit 3, lets trigger edges act; cleared means trigger ignored
// [RULE_08] run bit, bit 2, starts counting when 1, stops it when 0
// [RULE_09] function select, bit 1: 0 counts machine cycles, 1 counts count-pin falls
// [RULE_10] capture/reload select, bit 0: 1 captures on trigger, 0 reloads
// [RULE_11] any serial clock select forces auto-reload on overflow, ignoring bit 0
// [RULE_12] counter is 16 bits, high byte and low byte of 8 bits each
// [RULE_13] timer function increments once per machine cycle of 12 oscillator periods
// [RULE_14] run with selects decodes auto-reload, capture or baud generation
// [RULE_15] count pin sampled at S5P2; high then low sample counts one
// [RULE_16] new count shows at S3P1 of the machine cycle after detection
// [RULE_17] external count rate at most one per 24 oscillator periods
// [RULE_18] count-pin driver holds each level at least one machine cycle
// [RULE_19] reload register pair holds captured value or reload value
// [RULE_20] software writes no ones to unlisted special register locations
// [RULE_21] capture copies counter high and low bytes into reload high and low
// [RULE_22] up-count overflow past ffff loads counter from reload pair; with capture select 1 and no serial clock select the code loads 0000
// [RULE_23] baud generation timer function advances every state time
// [RULE_24] trigger pin falls detected with the same two-sample scheme
// [RULE_25] hardware set in the same cycle as software clear keeps the flag set
`default_nettype none
`include "t2crc_defines.vh"

module t2crc (
	input  wire       I_CLK,
	input  wire       I_RST,
	input  wire [7:0] I_SFR_ADDR,
	input  wire       I_SFR_WR,
	input  wire       I_SFR_RD,
	input  wire [7:0] I_SFR_WDATA,
	output reg  [7:0] O_SFR_RDATA,
	input  wire       I_COUNT_PIN,
	output wire       O_COUNT_PIN,
	output wire       O_COUNT_PIN_OE,
	input  wire       I_TRIGGER_PIN,
	input  wire       I_TIMER_INT_EN,
	output wire       O_TIMER_INT_REQ,
	input  wire       I_TIMER1_OVF,
	output wire       O_RX_CLK_TICK,
	output wire       O_TX_CLK_TICK
);

	// register state
	reg  [7:0]  ctrl_r;
	reg  [1:0]  mode_r;
	reg  [15:0] cnt_r;
	reg  [15:0] rld_r;
	reg         cnt_pend_r;
	reg         ovf_pulse_r;
	reg         clk_out_r;

	reg  [7:0]  ctrl_nxt;
	reg  [15:0] cnt_nxt;
	reg  [15:0] rld_nxt;
	reg         ovf_evt;
	reg         ovf_flag_set;
	reg         ext_flag_set;
	reg         ext_flag_tog;
	reg         ext_base;

	wire        mc_tick;
	wire        sample_tick;
	wire        state_tick;
	wire        cnt_fall;
	wire        trig_fall;
	wire        trig_level;

	// control fields
	wire overflow_flag         = ctrl_r[`T2CRC_CTRL_OVF];
	wire external_flag         = ctrl_r[`T2CRC_CTRL_EXT];
	wire receive_clock_select  = ctrl_r[`T2CRC_CTRL_RCLK];
	wire transmit_clock_select = ctrl_r[`T2CRC_CTRL_TRANSMIT_CLOCK_SELECT];
	wire external_enable       = ctrl_r[`T2CRC_CTRL_EXEN];
	wire run_bit               = ctrl_r[`T2CRC_CTRL_RUN];
	wire function_select       = ctrl_r[`T2CRC_CTRL_FUNC];
	wire capture_reload_select = ctrl_r[`T2CRC_CTRL_CPRL];
	wire direction_enable      = mode_r[`T2CRC_MODE_DIRECTION_ENABLE];
	wire clock_out_enable      = mode_r[`T2CRC_MODE_OE];

	wire baud_mode  = receive_clock_select | transmit_clock_select;
	wire clk_out_on = clock_out_enable & ~function_select;
	wire up_down    = direction_enable & ~capture_reload_select & ~baud_mode;

	// special register access decode
	wire wr_ctrl   = I_SFR_WR & (I_SFR_ADDR == `T2CRC_ADDR_CTRL);
	wire wr_mode   = I_SFR_WR & (I_SFR_ADDR == `T2CRC_ADDR_MODE);
	wire wr_rld_lo = I_SFR_WR & (I_SFR_ADDR == `T2CRC_ADDR_RLD_LO);
	wire wr_rld_hi = I_SFR_WR & (I_SFR_ADDR == `T2CRC_ADDR_RLD_HI);
	wire wr_cnt_lo = I_SFR_WR & (I_SFR_ADDR == `T2CRC_ADDR_CNT_LO);
	wire wr_cnt_hi = I_SFR_WR & (I_SFR_ADDR == `T2CRC_ADDR_CNT_HI);

	t2crc_phase #(
		.OSC_PER_MC   (`T2CRC_OSC_PER_MC),
		.PHASE_UPDATE (`T2CRC_PHASE_S3P1),
		.PHASE_SAMPLE (`T2CRC_PHASE_S5P2)
	) u_phase (
		.i_clk         (I_CLK),
		.i_rst         (I_RST),
		.o_mc_tick     (mc_tick),      // [RULE_13]
		.o_sample_tick (sample_tick),
		.o_state_tick  (state_tick)
	);

	// count pin, sampled once per machine cycle at S5P2
	t2crc_fall_det u_cnt_det (
		.i_clk    (I_CLK),
		.i_rst    (I_RST),
		.i_sample (sample_tick),       // [RULE_15] [RULE_17]
		.i_pin    (I_COUNT_PIN),
		.o_level  (),
		.o_fall   (cnt_fall)
	);

	// trigger pin, same sampling as the count pin
	t2crc_fall_det u_trig_det (
		.i_clk    (I_CLK),
		.i_rst    (I_RST),
		.i_sample (sample_tick),       // [RULE_24]
		.i_pin    (I_TRIGGER_PIN),
		.o_level  (trig_level),
		.o_fall   (trig_fall)
	);

	// a detected count-pin fall waits for S3P1 of the next machine cycle
	wire cnt_apply = cnt_pend_r & mc_tick;                    // [RULE_16]

	// increment source selection
	wire inc_src = function_select ? cnt_apply :              // [RULE_09]
		((baud_mode | clk_out_on) ? state_tick : mc_tick);    // [RULE_23] [RULE_13]
	wire inc     = run_bit & inc_src;                          // [RULE_08] [RULE_14]

	// trigger event only honoured with external enable
	wire trig_evt = trig_fall & external_enable;               // [RULE_07]

	always @* begin
		cnt_nxt      = cnt_r;
		rld_nxt      = rld_r;
		ovf_evt      = 1'b0;
		ovf_flag_set = 1'b0;
		ext_flag_set = 1'b0;
		ext_flag_tog = 1'b0;
		if (inc) begin
			if (up_down) begin
				if (trig_level) begin
					if (cnt_r == `T2CRC_CNT_MAX) begin
						cnt_nxt      = rld_r;                  // [RULE_22]
						ovf_evt      = 1'b1;
						ovf_flag_set = 1'b1;                   // [RULE_01]
						ext_flag_tog = 1'b1;
					end else begin
						cnt_nxt = cnt_r + 16'h0001;
					end
				end else begin
					if (cnt_r == rld_r) begin
						cnt_nxt      = `T2CRC_CNT_MAX;
						ovf_evt      = 1'b1;
						ovf_flag_set = 1'b1;                   // [RULE_01]
						ext_flag_tog = 1'b1;
					end else begin
						cnt_nxt = cnt_r - 16'h0001;
					end
				end
			end else if (cnt_r == `T2CRC_CNT_MAX) begin
				ovf_evt      = 1'b1;
				ovf_flag_set = ~baud_mode;                     // [RULE_01] [RULE_02]
				if (baud_mode | ~capture_reload_select) begin  // [RULE_11] [RULE_10]
					cnt_nxt = rld_r;                           // [RULE_22] [RULE_19]
				end else begin
					cnt_nxt = `T2CRC_CNT_ZERO;
				end
			end else begin
				cnt_nxt = cnt_r + 16'h0001;                    // [RULE_12]
			end
		end
		if (trig_evt & ~up_down) begin
			ext_flag_set = 1'b1;                               // [RULE_03]
			if (~baud_mode) begin                              // [RULE_11]
				if (capture_reload_select) begin
					rld_nxt = cnt_r;                           // [RULE_21] [RULE_10] [RULE_19]
				end else begin
					cnt_nxt = rld_r;                           // [RULE_10]
				end
			end
		end
		// software writes to data registers override the hardware update
		if (wr_cnt_lo) begin
			cnt_nxt[7:0] = I_SFR_WDATA;
		end
		if (wr_cnt_hi) begin
			cnt_nxt[15:8] = I_SFR_WDATA;
		end
		if (wr_rld_lo) begin
			rld_nxt[7:0] = I_SFR_WDATA;
		end
		if (wr_rld_hi) begin
			rld_nxt[15:8] = I_SFR_WDATA;
		end
	end

	// control register: flags keep a hardware set over a software clear
	always @* begin
		ctrl_nxt = wr_ctrl ? I_SFR_WDATA : ctrl_r;
		ext_base = ctrl_nxt[`T2CRC_CTRL_EXT];
		ctrl_nxt[`T2CRC_CTRL_OVF] = ovf_flag_set | ctrl_nxt[`T2CRC_CTRL_OVF];  // [RULE_25]
		ctrl_nxt[`T2CRC_CTRL_EXT] = ext_flag_set | (ext_flag_tog ? ~ext_base : ext_base); // [RULE_25]
	end

	always @(posedge I_CLK) begin
		if (I_RST) begin
			ctrl_r      <= `T2CRC_RST_CTRL;
			mode_r      <= `T2CRC_RST_MODE;
			cnt_r       <= {`T2CRC_RST_BYTE, `T2CRC_RST_BYTE};
			rld_r       <= {`T2CRC_RST_BYTE, `T2CRC_RST_BYTE};
			cnt_pend_r  <= 1'b0;
			ovf_pulse_r <= 1'b0;
			clk_out_r   <= 1'b0;
		end else begin
			ctrl_r      <= ctrl_nxt;
			cnt_r       <= cnt_nxt;
			rld_r       <= rld_nxt;
			ovf_pulse_r <= ovf_evt;
			if (wr_mode) begin
				mode_r <= I_SFR_WDATA[1:0];
			end
			if (cnt_fall) begin
				cnt_pend_r <= 1'b1;                            // [RULE_15]
			end else if (mc_tick) begin
				cnt_pend_r <= 1'b0;                            // [RULE_16]
			end
			if (~clk_out_on) begin
				clk_out_r <= 1'b0;
			end else if (ovf_evt) begin
				clk_out_r <= ~clk_out_r;
			end
		end
	end

	// read data, unmapped addresses and unused mode bits read zero
	always @(posedge I_CLK) begin
		if (I_RST) begin
			O_SFR_RDATA <= 8'h00;
		end else if (I_SFR_RD) begin
			case (I_SFR_ADDR)
				`T2CRC_ADDR_CTRL:   O_SFR_RDATA <= ctrl_r;
				`T2CRC_ADDR_MODE:   O_SFR_RDATA <= {6'h00, mode_r};
				`T2CRC_ADDR_RLD_LO: O_SFR_RDATA <= rld_r[7:0];
				`T2CRC_ADDR_RLD_HI: O_SFR_RDATA <= rld_r[15:8];
				`T2CRC_ADDR_CNT_LO: O_SFR_RDATA <= cnt_r[7:0];
				`T2CRC_ADDR_CNT_HI: O_SFR_RDATA <= cnt_r[15:8];
				default:            O_SFR_RDATA <= 8'h00;
			endcase
		end
	end

	assign O_TIMER_INT_REQ = I_TIMER_INT_EN &
		(overflow_flag | (external_flag & ~direction_enable)); // [RULE_04]

	assign O_RX_CLK_TICK = receive_clock_select ? ovf_pulse_r : I_TIMER1_OVF;  // [RULE_05]
	assign O_TX_CLK_TICK = transmit_clock_select ? ovf_pulse_r : I_TIMER1_OVF; // [RULE_06]

	// clock-out drives the count pin, toggling on each rollover
	assign O_COUNT_PIN    = clk_out_r;
	assign O_COUNT_PIN_OE = clk_out_on;

endmodule

`default_nettype wire

// [logic/t2crc_fall_det.v]
`default_nettype none

// samples a pin once per machine cycle, flags a high sample followed by a low one
module t2crc_fall_det (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire       i_sample,
	input  wire       i_pin,
	output reg        o_level,
	output reg        o_fall
);

	always @(posedge i_clk) begin
		if (i_rst) begin
			o_level <= 1'b1;
			o_fall  <= 1'b0;
		end else begin
			o_fall <= i_sample & o_level & ~i_pin;
			if (i_sample) begin
				o_level <= i_pin;
			end
		end
	end

endmodule

`default_nettype wire

// [logic/t2crc_phase.v]
`default_nettype none
`include "t2crc_defines.vh"

// machine-cycle phase generator: one phase per oscillator period
module t2crc_phase #(
	parameter integer OSC_PER_MC   = `T2CRC_OSC_PER_MC,
	parameter integer PHASE_UPDATE = `T2CRC_PHASE_S3P1,
	parameter integer PHASE_SAMPLE = `T2CRC_PHASE_S5P2
) (
	input  wire       i_clk,
	input  wire       i_rst,
	output reg        o_mc_tick,
	output reg        o_sample_tick,
	output reg        o_state_tick
);

	reg  [3:0] phase_r;
	wire [3:0] phase_nxt;

	assign phase_nxt = (phase_r == OSC_PER_MC[3:0] - 4'h1) ? 4'h0 : phase_r + 4'h1;

	always @(posedge i_clk) begin
		if (i_rst) begin
			phase_r       <= 4'h0;
			o_mc_tick     <= 1'b0;
			o_sample_tick <= 1'b0;
			o_state_tick  <= 1'b0;
		end else begin
			phase_r       <= phase_nxt;
			o_mc_tick     <= (phase_nxt == PHASE_UPDATE[3:0]);
			o_sample_tick <= (phase_nxt == PHASE_SAMPLE[3:0]);
			// one pulse per state time, every second oscillator period
			o_state_tick  <= phase_nxt[0];
		end
	end

endmodule

`default_nettype wire

// [tb/t2crc_asserts.sv]
`default_nettype none
`include "t2crc_defines.vh"
module t2crc_asserts (
	input wire logic       I_CLK,
	input wire logic       I_RST,
	input wire logic [7:0] I_SFR_ADDR,
	input wire logic       I_SFR_WR,
	input wire logic       I_SFR_RD,
	input wire logic [7:0] I_SFR_WDATA,
	input wire logic [7:0] O_SFR_RDATA,
	input wire logic       I_COUNT_PIN,
	input wire logic       O_COUNT_PIN,
	input wire logic       O_COUNT_PIN_OE,
	input wire logic       I_TRIGGER_PIN,
	input wire logic       I_TIMER_INT_EN,
	input wire logic       O_TIMER_INT_REQ,
	input wire logic       I_TIMER1_OVF,
	input wire logic       O_RX_CLK_TICK,
	input wire logic       O_TX_CLK_TICK
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] ctrl_r;
	logic [1:0] mode_r;
	// shadows of the software-owned control bits
	always @(posedge I_CLK) begin
		if (I_RST) begin
			ctrl_r <= 6'h00;
			mode_r <= 2'h0;
		end else if (I_SFR_WR) begin
			if (I_SFR_ADDR == `T2CRC_ADDR_CTRL)
				ctrl_r <= I_SFR_WDATA[5:0];
			if (I_SFR_ADDR == `T2CRC_ADDR_MODE)
				mode_r <= I_SFR_WDATA[1:0];
		end
	end
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	sequence rd_at(a);
		I_SFR_RD && !I_SFR_WR && I_SFR_ADDR == a;
	endsequence
	sequence baud_tick;
		ctrl_r[5] && O_RX_CLK_TICK;
	endsequence
	rx_select_a: assert property (!ctrl_r[5] |-> O_RX_CLK_TICK == I_TIMER1_OVF)
		else $error("rx tick source wrong");
	tx_select_a: assert property (!ctrl_r[4] |-> O_TX_CLK_TICK == I_TIMER1_OVF)
		else $error("tx tick source wrong");
	int_mask_a: assert property (!I_TIMER_INT_EN |-> !O_TIMER_INT_REQ)
		else $error("request while disabled");
	int_hold_a: assert property (O_TIMER_INT_REQ && I_TIMER_INT_EN && !(I_SFR_WR &&
		I_SFR_ADDR inside {`T2CRC_ADDR_CTRL, `T2CRC_ADDR_MODE}) |=> O_TIMER_INT_REQ)
		else $error("flag dropped without software");
	stop_quiet_a: assert property (!ctrl_r[2] [*3] |-> not baud_tick)
		else $error("overflow while stopped");
	baud_space_a: assert property (baud_tick ##1 ctrl_r[5] |-> !O_RX_CLK_TICK)
		else $error("baud ticks too close");
	pin_enable_a: assert property (O_COUNT_PIN_OE == (mode_r[1] && !ctrl_r[1]))
		else $error("count pin enable wrong");
	ctrl_read_a: assert property (rd_at(`T2CRC_ADDR_CTRL) |=> O_SFR_RDATA[5:0] == $past(ctrl_r))
		else $error("control readback wrong");
	mode_read_a: assert property (rd_at(`T2CRC_ADDR_MODE) |=> O_SFR_RDATA == {6'h00, $past(mode_r)})
		else $error("mode readback wrong");
endmodule
bind t2crc t2crc_asserts CHK (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WR(I_SFR_WR),
	.I_SFR_RD(I_SFR_RD), .I_SFR_WDATA(I_SFR_WDATA), .O_SFR_RDATA(O_SFR_RDATA),
	.I_COUNT_PIN(I_COUNT_PIN), .O_COUNT_PIN(O_COUNT_PIN), .O_COUNT_PIN_OE(O_COUNT_PIN_OE),
	.I_TRIGGER_PIN(I_TRIGGER_PIN), .I_TIMER_INT_EN(I_TIMER_INT_EN),
	.O_TIMER_INT_REQ(O_TIMER_INT_REQ), .I_TIMER1_OVF(I_TIMER1_OVF),
	.O_RX_CLK_TICK(O_RX_CLK_TICK), .O_TX_CLK_TICK(O_TX_CLK_TICK)
);
`default_nettype wire

// [tb/t2crc_pins.sv]
`default_nettype none
module t2crc_pins (
	input  wire logic i_clk,
	output var logic  o_count_pin,
	output var logic  o_trigger_pin,
	output var logic  o_timer1_ovf
);
	timeunit 1ns;
	timeprecision 100ps;
	int t1_cnt = 0;
	initial begin
		o_count_pin = 1'b1;
		o_trigger_pin = 1'b1;
		o_timer1_ovf = 1'b0;
	end
	always @(posedge i_clk) begin
		t1_cnt <= (t1_cnt == 15) ? 0 : t1_cnt + 1;
		o_timer1_ovf <= (t1_cnt == 15);
	end
	// trigger level steers the count direction in up/down mode
	task automatic hold_trig(input bit lv);
		@(posedge i_clk);
		o_trigger_pin <= lv;
	endtask
	// each level held past one machine cycle so every level is sampled
	task automatic fall(input bit trig, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			if (trig) o_trigger_pin <= 1'b0; else o_count_pin <= 1'b0;
			repeat (13) @(posedge i_clk);
			if (trig) o_trigger_pin <= 1'b1; else o_count_pin <= 1'b1;
			repeat (13) @(posedge i_clk);
		end
	endtask
endmodule
`default_nettype wire

// [tb/tb_timer2_capture_reload_counter.sv]
`default_nettype none
`include "t2crc_defines.vh"
module tb_timer2_capture_reload_counter;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] CT = `T2CRC_ADDR_CTRL;
	localparam logic [7:0] MD = `T2CRC_ADDR_MODE;
	localparam logic [7:0] RL = `T2CRC_ADDR_RLD_LO;
	localparam logic [7:0] CN = `T2CRC_ADDR_CNT_LO;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, int_en = 0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdat, got, m;
	logic        cpo, oe, irq, rxt, txt, cpin, tpin, t1;
	logic [15:0] v, r;
	integer      seed = 32'h2f1ca79e;
	int          fails = 0, check_count = 0, cyc = 0, t_a, k;
	initial forever #12.5 clk = ~clk;
	// counted on the rising edge so reads at the falling edge never race it
	always @(posedge clk) cyc <= cyc + 1;
	t2crc DUT (.I_CLK(clk), .I_RST(rst), .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd),
		.I_SFR_WDATA(wdata), .O_SFR_RDATA(rdat), .I_COUNT_PIN(cpin), .O_COUNT_PIN(cpo),
		.O_COUNT_PIN_OE(oe), .I_TRIGGER_PIN(tpin), .I_TIMER_INT_EN(int_en),
		.O_TIMER_INT_REQ(irq), .I_TIMER1_OVF(t1), .O_RX_CLK_TICK(rxt), .O_TX_CLK_TICK(txt));
	t2crc_pins PRT (.i_clk(clk), .o_count_pin(cpin), .o_trigger_pin(tpin), .o_timer1_ovf(t1));
	function automatic logic [15:0] gap(input logic [15:0] rl, input int rate);
		return 16'((17'h10000 - {1'b0, rl}) * rate);
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr_r(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd_r(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdat;
	endtask
	task automatic set16(input logic [7:0] a, input logic [15:0] d);
		wr_r(a, d[7:0]);
		wr_r(a + 8'h01, d[15:8]);
	endtask
	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		rd_r(a, d[7:0]);
		rd_r(a + 8'h01, d[15:8]);
	endtask
	// waits at falling edges for request, receive tick or clock-out level, bounded
	task automatic wait_hi(input int sel);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!((sel == 1) ? irq : (sel == 2) ? cpo : (sel == 3) ? !cpo : rxt) && n < 2000);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#500000;
		fails++;
		stop_test;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int a = 'hc7; a <= 'hce; a++) begin
			rd_r(8'(a), got);
			chk({8'h00, got}, 16'h0000);
		end
		for (int i = 0; i < 4; i++) begin
			m = 8'($random(seed));
			wr_r(CT, m & 8'h39);
			rd_r(CT, got);
			chk({8'h00, got}, {8'h00, m & 8'h39});
			wr_r(MD, m);
			rd_r(MD, got);
			chk({8'h00, got}, {8'h00, m & 8'h03});
			chk({15'h0, oe}, {15'h0, m[1]});
		end
		wr_r(MD, 8'h00);
		@(posedge clk) int_en <= 1'b1;
		set16(RL, 16'hfff0);
		set16(CN, 16'hfff0);
		wr_r(CT, 8'h35);
		wait_hi(0);
		t_a = cyc;
		wait_hi(0);
		chk(16'(cyc - t_a), gap(16'hfff0, 2));
		chk({15'h0, txt}, 16'h0001);
		chk({15'h0, irq}, 16'h0000);
		wr_r(CT, 8'h00);
		set16(RL, 16'hfffd);
		set16(CN, 16'hfffd);
		wr_r(CT, 8'h04);
		wait_hi(1);
		t_a = cyc;
		wr_r(CT, 8'h04);
		wait_hi(1);
		chk(16'(cyc - t_a), gap(16'hfffd, 12));
		rd_r(CT, got);
		chk({8'h00, got}, 16'h0084);
		for (int e = 0; e < 3; e++) begin
			wr_r(CT, 8'h00);
			v = 16'($random(seed));
			set16(CN, v);
			set16(RL, 16'h0000);
			wr_r(CT, (e == 0) ? 8'h01 : ((e == 1) ? 8'h09 : 8'h08));
			PRT.fall(1'b1, 1);
			rd16(RL, r);
			chk(r, (e == 1) ? v : 16'h0000);
			rd16(CN, r);
			chk(r, (e == 2) ? 16'h0000 : v);
			chk({15'h0, irq}, {15'h0, e != 0});
		end
		wr_r(MD, 8'h01);
		chk({15'h0, irq}, 16'h0000);
		wr_r(MD, 8'h00);
		wr_r(CT, 8'h00);
		chk({15'h0, irq}, 16'h0000);
		set16(CN, 16'h0000);
		wr_r(CT, 8'h06);
		k = ($random(seed) & 7) + 1;
		PRT.fall(1'b0, k);
		repeat (24) @(posedge clk);
		wr_r(CT, 8'h00);
		rd16(CN, v);
		chk(v, 16'(k));
		// clock-out: pin toggles on each rollover at the state rate
		set16(RL, 16'hfff0);
		set16(CN, 16'hfff0);
		wr_r(MD, 8'h02);
		wr_r(CT, 8'h04);
		chk({15'h0, oe}, 16'h0001);
		wait_hi(2);
		t_a = cyc;
		wait_hi(3);
		chk(16'(cyc - t_a), gap(16'hfff0, 2));
		// up/down with trigger low: counts down, underflow at the reload value
		wr_r(CT, 8'h00);
		wr_r(MD, 8'h01);
		PRT.hold_trig(1'b0);
		set16(RL, 16'h0005);
		set16(CN, 16'h0007);
		wr_r(CT, 8'h04);
		wait_hi(1);
		rd_r(CT, got);
		chk({8'h00, got}, 16'h00c4);
		wr_r(CT, 8'h00);
		rd16(CN, r);
		chk(r, 16'hffff);
		PRT.hold_trig(1'b1);
		stop_test;
	end
endmodule
`default_nettype wire
